// ===== hdl/airq_pkg.sv
package airq_pkg;
    // ****************************************
    // Register indices (byte address = 4 x index)
    // ****************************************
    localparam logic [7:0] IDX_ENABLE_CLEAR = 8'h16;
    localparam logic [7:0] IDX_ENABLE_SET = 8'h17;
    localparam logic [7:0] IDX_FLAGS = 8'h18;
    localparam logic [7:0] IDX_STATUS = 8'h19;
    localparam logic [7:0] IDX_RESULT = 8'h1a;
    localparam logic [7:0] IDX_WIN_LOW = 8'h1c;
    localparam logic [7:0] IDX_CONTROL_SECOND = 8'h30;
    localparam int ADDR_LSB = 2;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_RESULT_VALID = 0;
    localparam int BIT_OVERRUN = 1;
    localparam int BIT_WINDOW_MATCH = 2;
    localparam int BIT_SYNC_DONE = 3;
    localparam int NUM_SRC = 4;
    localparam int BIT_SYNC_PENDING = 7;
    localparam int BIT_LEFT_JUSTIFY = 0;
    localparam int BIT_WINDOW_ENABLE = 1;
    localparam int RAW_BITS = 12;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0] RST_ENABLE = 4'h0;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [15:0] RST_RESULT = 16'h0000;
    localparam logic [15:0] RST_WIN_LOW = 16'h0000;
    localparam logic [1:0] RST_CONTROL = 2'h0;

    // ****************************************
    // Timing: register synchronisation time
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int SYNC_TIME_NS = 12;
    localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // Bus answers
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== hdl/airq_justify.sv
`timescale 1ns/10ps
`default_nettype none
module airq_justify
    import airq_pkg::*;
(
    // Raw value from the converter core
    input wire logic [15:0] raw,
    input wire logic oversample,
    // Placement control
    input wire logic left_justify,
    // Placed value
    output logic [15:0] placed
);
    // Place the 12-bit value, or pass the accumulated value whole
    always_comb begin
        if (oversample) begin
            placed = raw;
        end else if (left_justify) begin
            placed = {raw[RAW_BITS-1:0], 4'h0};
        end else begin
            placed = {4'h0, raw[RAW_BITS-1:0]};
        end
    end
endmodule
`default_nettype wire

// ===== hdl/airq_syncmon.sv
`timescale 1ns/10ps
`default_nettype none
module airq_syncmon
    import airq_pkg::*;
#(
    parameter int CYCLES = SYNC_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Starts of synchronisation
    input wire logic start_loud,
    input wire logic start_quiet,
    // Status
    output logic busy,
    output logic done
);
    logic [7:0] count;
    logic quiet;

    // Busy counter, restarted by any start
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 8'h00;
        end else if (start_loud || start_quiet) begin
            count <= 8'(CYCLES);
        end else if (count != 8'h00) begin
            count <= count - 8'h01;
        end
    end

    // Remember whether the running sync is quiet
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            quiet <= 1'b0;
        end else if (start_quiet) begin
            quiet <= 1'b1;
        end else if (start_loud) begin
            quiet <= 1'b0;
        end
    end

    assign busy = (count != 8'h00);
    // Falling edge of busy, suppressed for quiet syncs
    assign done = (count == 8'h01) && !start_loud && !start_quiet && !quiet;
endmodule
`default_nettype wire

// ===== hdl/airq_regs.sv
// Notes on behaviour
// - Writing one to an enable-clear bit disables that source and drops its request.
// - Writing one to an enable-set bit enables that source; zeros ignored.
// - Enable-set and enable-clear read back the same enable bits.
// - Each source requests an interrupt while its flag and enable are both one.
// - The four low flag bits clear on writing one; zero writes do nothing.
// - sync_done sets when sync_pending falls, unless enable or soft reset began it.
// - window_match sets the cycle after a result meets the window condition.
// - overrun sets when a new result lands before the old one was read.
// - result_valid sets when a new result becomes readable.
// - Status bit 7 shows sync_pending, read only, high during synchronisation.
// - Reserved bits read zero; software writes them as zero.
// - Result register is 16-bit, read only, resets to zero.
// - Single-ended unaveraged results are 12 bits, placed per left_justify.
// - Left-justified: upper eight bits in [15:8], low four bits in [7:4].
// - Right-justified without oversampling: result in [11:0].
// - With oversampling the accumulated value spans [15:0].
// - window_low_limit is the lower threshold for the window monitor.
`timescale 1ns/10ps
`default_nettype none
module airq_regs
    import airq_pkg::*;
#(
    parameter int SYNC_LEN = SYNC_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Converter core events
    input wire logic conv_done,
    input wire logic [15:0] conv_raw,
    input wire logic oversample,
    input wire logic module_enable_start,
    input wire logic soft_reset_start,
    // Control towards the converter core
    output logic left_justify,
    output logic window_enable,
    output logic [15:0] window_low_limit,
    output logic sync_pending,
    // Interrupts
    output logic [3:0] irq_req,
    output logic irq
);
    // ****************************************
    // Storage
    // ****************************************
    logic [3:0] irq_enable;
    logic [3:0] irq_flags;
    logic [15:0] conversion_result;
    logic result_unread;
    logic match_seen;
    logic [1:0] control_second;

    // Write channel holding
    logic aw_held;
    logic w_held;
    logic [7:0] aw_index;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic write_fire;
    logic write_hit;

    // Read side decode
    logic read_fire;
    logic [7:0] ar_index;
    logic result_read;

    // Event strobes
    logic [3:0] set_ev;
    logic [3:0] clr_flag;
    logic [3:0] set_en;
    logic [3:0] clr_en;
    logic [15:0] placed;
    logic window_hit;
    logic sync_done_ev;
    logic win_low_write;

    // ****************************************
    // Write channel
    // ****************************************
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign write_fire = aw_held && w_held && !s_axi_bvalid;

    // Capture write address
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held <= 1'b0;
            aw_index <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_index <= s_axi_awaddr[9:ADDR_LSB];
        end else if (write_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Capture write data
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (write_fire) begin
            w_held <= 1'b0;
        end
    end

    // Decode which registers accept a write
    always_comb begin
        case (aw_index)
            IDX_ENABLE_CLEAR, IDX_ENABLE_SET, IDX_FLAGS, IDX_STATUS,
            IDX_RESULT, IDX_WIN_LOW, IDX_CONTROL_SECOND: write_hit = 1'b1;
            default: write_hit = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Write strobes, low byte lane; the lower threshold uses either of the low two lanes
    assign set_en = (write_fire && aw_index == IDX_ENABLE_SET && w_strb[0]) ?
        w_data[3:0] : 4'h0;
    assign clr_en = (write_fire && aw_index == IDX_ENABLE_CLEAR && w_strb[0]) ?
        w_data[3:0] : 4'h0;
    assign clr_flag = (write_fire && aw_index == IDX_FLAGS && w_strb[0]) ?
        w_data[3:0] : 4'h0;
    assign win_low_write = write_fire && aw_index == IDX_WIN_LOW && (|w_strb[1:0]);

    // ****************************************
    // Enables, shared by set and clear views
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_enable <= RST_ENABLE;
        end else begin
            irq_enable <= (irq_enable | set_en) & ~clr_en;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            control_second <= RST_CONTROL;
        end else if (write_fire && aw_index == IDX_CONTROL_SECOND && w_strb[0]) begin
            control_second <= w_data[1:0];
        end
    end

    assign left_justify = control_second[BIT_LEFT_JUSTIFY];
    assign window_enable = control_second[BIT_WINDOW_ENABLE];

    // Lower threshold, byte-lane writable
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            window_low_limit <= RST_WIN_LOW;
        end else if (win_low_write) begin
            if (w_strb[0]) begin
                window_low_limit[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                window_low_limit[15:8] <= w_data[15:8];
            end
        end
    end

    // ****************************************
    // Register synchronisation tracking
    // ****************************************
    airq_syncmon #(
        .CYCLES(SYNC_LEN)
    ) u_syncmon (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .start_loud(win_low_write),
        .start_quiet(module_enable_start || soft_reset_start),
        .busy(sync_pending),
        .done(sync_done_ev)
    );

    // ****************************************
    // Result path
    // ****************************************
    airq_justify u_justify (
        .raw(conv_raw),
        .oversample(oversample),
        .left_justify(left_justify),
        .placed(placed)
    );

    // Result register loads on each completed conversion
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            conversion_result <= RST_RESULT;
        end else if (conv_done) begin
            conversion_result <= placed;
        end
    end

    // Unread tracking; a fresh result wins over a read in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            result_unread <= 1'b0;
        end else if (conv_done) begin
            result_unread <= 1'b1;
        end else if (result_read) begin
            result_unread <= 1'b0;
        end
    end

    // Window monitor: result at or above the lower threshold
    assign window_hit = conv_done && window_enable && (placed >= window_low_limit);

    // Delay the match by one cycle before it reaches the flag
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            match_seen <= 1'b0;
        end else begin
            match_seen <= window_hit;
        end
    end

    // ****************************************
    // Flags: set wins over clear
    // ****************************************
    always_comb begin
        set_ev = 4'h0;
        set_ev[BIT_RESULT_VALID] = conv_done;
        set_ev[BIT_OVERRUN] = conv_done && result_unread;
        set_ev[BIT_WINDOW_MATCH] = match_seen;
        set_ev[BIT_SYNC_DONE] = sync_done_ev;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_flags <= RST_FLAGS;
        end else begin
            irq_flags <= (irq_flags & ~clr_flag) | set_ev;
        end
    end

    // Per-source requests and the combined line
    assign irq_req = irq_flags & irq_enable;
    assign irq = |irq_req;

    // ****************************************
    // Read channel
    // ****************************************
    assign s_axi_arready = !s_axi_rvalid;
    assign read_fire = s_axi_arvalid && s_axi_arready;
    assign ar_index = s_axi_araddr[9:ADDR_LSB];
    assign result_read = read_fire && ar_index == IDX_RESULT;

    // Read data, reserved bits zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (read_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            case (ar_index)
                IDX_ENABLE_CLEAR, IDX_ENABLE_SET: begin
                    s_axi_rdata[3:0] <= irq_enable;
                end
                IDX_FLAGS: begin
                    s_axi_rdata[3:0] <= irq_flags;
                end
                IDX_STATUS: begin
                    s_axi_rdata[BIT_SYNC_PENDING] <= sync_pending;
                end
                IDX_RESULT: begin
                    s_axi_rdata[15:0] <= conversion_result;
                end
                IDX_WIN_LOW: begin
                    s_axi_rdata[15:0] <= window_low_limit;
                end
                IDX_CONTROL_SECOND: begin
                    s_axi_rdata[1:0] <= control_second;
                end
                default: begin
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Protection bits carry no meaning here
    logic prot_unused;
    assign prot_unused = ^{s_axi_awprot, s_axi_arprot, w_strb[3:2]};
endmodule
`default_nettype wire

// ===== tb/airq_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module airq_regs_chk
    import airq_pkg::*;
#(
    parameter int SYNC_LEN = SYNC_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // Converter side and interrupts
    input wire logic module_enable_start,
    input wire logic soft_reset_start,
    input wire logic [15:0] window_low_limit,
    input wire logic sync_pending,
    input wire logic [3:0] irq_req,
    input wire logic irq
);
    localparam logic [9:0] A_CLR = {IDX_ENABLE_CLEAR, 2'h0};
    localparam logic [9:0] A_SET = {IDX_ENABLE_SET, 2'h0};
    localparam logic [9:0] A_FLG = {IDX_FLAGS, 2'h0};
    localparam logic [9:0] A_STS = {IDX_STATUS, 2'h0};
    localparam logic [9:0] A_RES = {IDX_RESULT, 2'h0};
    localparam logic [9:0] A_WLO = {IDX_WIN_LOW, 2'h0};
    logic [9:0] wa, ra;
    logic [31:0] wd;
    logic rsp, quiet;
    logic [7:0] cnt;
    // Captures bus state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wa <= 10'h000;
            ra <= 10'h000;
            wd <= 32'h0000_0000;
            rsp <= 1'h0;
            quiet <= 1'h0;
            cnt <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                wa <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                wd <= s_axi_wdata;
            if (s_axi_arvalid && s_axi_arready) begin
                ra <= s_axi_araddr;
                rsp <= sync_pending;
            end
            if (module_enable_start || soft_reset_start)
                quiet <= 1'h1;
            else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == A_WLO)
                quiet <= 1'h0;
            cnt <= sync_pending ? cnt + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ****************************************
    // Properties
    // ****************************************
    property p_irq_any; irq == (|irq_req); endproperty
    a_irq_any: assert property (p_irq_any) else $error("irq not OR of requests");
    property p_clr_drop; $rose(s_axi_bvalid) && wa == A_CLR |-> (irq_req & wd[3:0]) == 4'h0; endproperty
    a_clr_drop: assert property (p_clr_drop) else $error("request kept after enable clear");
    property p_flag_clr; $rose(s_axi_bvalid) && wa == A_FLG |-> (irq_req & wd[3:0]) == 4'h0; endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("request kept after flag clear");
    property p_low_rsv;
        s_axi_rvalid && (ra == A_CLR || ra == A_SET || ra == A_FLG) |-> s_axi_rdata[31:4] == 28'h0;
    endproperty
    a_low_rsv: assert property (p_low_rsv) else $error("reserved bits read nonzero");
    property p_stat; s_axi_rvalid && ra == A_STS |-> s_axi_rdata == {24'h00_0000, rsp, 7'h00}; endproperty
    a_stat: assert property (p_stat) else $error("status read wrong");
    property p_res16; s_axi_rvalid && ra == A_RES |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_res16: assert property (p_res16) else $error("result upper bits set");
    property p_sync_len; $fell(sync_pending) |-> cnt == SYNC_LEN; endproperty
    a_sync_len: assert property (p_sync_len) else $error("sync busy length wrong");
    property p_quiet; $fell(sync_pending) && quiet |-> !$rose(irq_req[3]) ##1 !$rose(irq_req[3]); endproperty
    a_quiet: assert property (p_quiet) else $error("sync done after quiet start");
    property p_win; $rose(s_axi_bvalid) && wa == A_WLO |-> window_low_limit == wd[15:0]; endproperty
    a_win: assert property (p_win) else $error("lower limit stale");
    c_irq: cover property (irq);
    c_sync: cover property ($fell(sync_pending));
    c_res: cover property (s_axi_rvalid && ra == A_RES);
endmodule
bind airq_regs airq_regs_chk #(.SYNC_LEN(SYNC_LEN)) chk_u (.ref_clk, .rst_b, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata,
    .module_enable_start, .soft_reset_start, .window_low_limit, .sync_pending, .irq_req, .irq);
`default_nettype wire

// ===== tb/adc_irq_result_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adc_irq_result_regs_bench
    import airq_pkg::*;
;
    logic ref_clk = 1'h0, rst_b = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_arvalid = 1'h0, s_axi_rready = 1'h1, conv_done = 1'h0;
    logic oversample = 1'h0, module_enable_start = 1'h0, soft_reset_start = 1'h0;
    logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf, irq_req;
    logic [15:0] conv_raw = 16'h0000, window_low_limit;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic left_justify, window_enable, sync_pending, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int n_fail = 0, n_checks = 0, cyc = 0;
    airq_regs #(.SYNC_LEN(6)) dut_u (.ref_clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .conv_done, .conv_raw, .oversample, .module_enable_start, .soft_reset_start,
        .left_justify, .window_enable, .window_low_limit, .sync_pending, .irq_req, .irq);
    // Clock at 250 MHz
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // ****************************************
    // Bus and check helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] v, output logic [1:0] rs);
        logic ta, tw, tb;
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(negedge ref_clk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge ref_clk);
            if (ta)
                s_axi_awvalid <= 1'h0;
            if (tw)
                s_axi_wvalid <= 1'h0;
        end while (!tb);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] rs);
        logic t;
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        do begin
            @(negedge ref_clk);
            t = s_axi_arready;
            @(posedge ref_clk);
        end while (!t);
        s_axi_arvalid <= 1'h0;
        do begin
            @(negedge ref_clk);
            t = s_axi_rvalid;
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge ref_clk);
        end while (!t);
    endtask
    task automatic wrok(input logic [7:0] idx, input logic [31:0] v);
        wr(idx, v, r);
        chk("bresp", r, RESP_OKAY);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        rd(idx, d, r);
        chk(nm, d, exp);
    endtask
    task automatic conv(input logic [15:0] v);
        conv_raw <= v;
        conv_done <= 1'h1;
        @(posedge ref_clk);
        conv_done <= 1'h0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic wait_sync;
        wait (sync_pending === 1'h0);
        @(posedge ref_clk);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        logic [7:0] idx [6];
        idx = '{IDX_ENABLE_CLEAR, IDX_ENABLE_SET, IDX_FLAGS, IDX_STATUS, IDX_RESULT, IDX_WIN_LOW};
        foreach (idx[i]) rdchk("reset value", idx[i], 32'h0000_0000);
        $display("reset done");
    endtask
    task automatic t_enable;
        wrok(IDX_ENABLE_SET, 32'h0000_0005);
        rdchk("enable via clear", IDX_ENABLE_CLEAR, 32'h0000_0005);
        wrok(IDX_ENABLE_SET, 32'h0000_000a);
        rdchk("enable set", IDX_ENABLE_SET, 32'h0000_000f);
        wrok(IDX_ENABLE_CLEAR, 32'h0000_0003);
        rdchk("enable via set", IDX_ENABLE_SET, 32'h0000_000c);
        wrok(IDX_ENABLE_SET, 32'h0000_0000);
        wrok(IDX_ENABLE_CLEAR, 32'h0000_0000);
        rdchk("zero writes", IDX_ENABLE_CLEAR, 32'h0000_000c);
        wrok(IDX_ENABLE_SET, 32'h0000_0003);
        $display("enable done");
    endtask
    task automatic t_result;
        wrok(IDX_CONTROL_SECOND, 32'h0000_0000);
        conv(16'h0abc);
        chk("request", irq_req, 4'h1);
        rdchk("ready flag", IDX_FLAGS, 32'h0000_0001);
        conv(16'h0123);
        rdchk("overrun flag", IDX_FLAGS, 32'h0000_0003);
        rdchk("right justified", IDX_RESULT, 32'h0000_0123);
        wrok(IDX_ENABLE_CLEAR, 32'h0000_0001);
        chk("masked request", irq_req, 4'h2);
        wrok(IDX_FLAGS, 32'h0000_0003);
        rdchk("flags cleared", IDX_FLAGS, 32'h0000_0000);
        chk("irq low", irq, 1'h0);
        conv(16'h0456);
        rdchk("twelve bit value", IDX_RESULT, 32'h0000_0456);
        conv(16'h0789);
        rdchk("read consumes", IDX_FLAGS, 32'h0000_0001);
        wrok(IDX_FLAGS, 32'h0000_0000);
        rdchk("zero write kept", IDX_FLAGS, 32'h0000_0001);
        wrok(IDX_CONTROL_SECOND, 32'h0000_0001);
        chk("left_justify", left_justify, 1'h1);
        conv(16'h0abc);
        rdchk("left justified", IDX_RESULT, 32'h0000_abc0);
        wrok(IDX_CONTROL_SECOND, 32'h0000_0000);
        oversample <= 1'h1;
        conv(16'hfedc);
        rdchk("oversampled", IDX_RESULT, 32'h0000_fedc);
        oversample <= 1'h0;
        wrok(IDX_FLAGS, 32'h0000_000f);
        $display("result done");
    endtask
    task automatic t_window;
        wrok(IDX_WIN_LOW, 32'h0000_0800);
        rdchk("sync busy", IDX_STATUS, 32'h0000_0080);
        wait_sync;
        rdchk("sync done flag", IDX_FLAGS, 32'h0000_0008);
        chk("limit output", window_low_limit, 16'h0800);
        wrok(IDX_CONTROL_SECOND, 32'h0000_0002);
        chk("window_enable", window_enable, 1'h1);
        wait_sync;
        wrok(IDX_FLAGS, 32'h0000_000f);
        conv(16'h07ff);
        rdchk("below limit", IDX_FLAGS, 32'h0000_0001);
        rdchk("below value", IDX_RESULT, 32'h0000_07ff);
        wrok(IDX_FLAGS, 32'h0000_000f);
        conv(16'h0800);
        rdchk("at limit", IDX_FLAGS, 32'h0000_0005);
        chk("window request", irq_req, 4'h4);
        wrok(IDX_CONTROL_SECOND, 32'h0000_0000);
        wrok(IDX_FLAGS, 32'h0000_000f);
        $display("window done");
    endtask
    task automatic t_quiet;
        for (int i = 0; i < 2; i++) begin
            module_enable_start <= (i == 0);
            soft_reset_start <= (i == 1);
            @(posedge ref_clk);
            module_enable_start <= 1'h0;
            soft_reset_start <= 1'h0;
            rdchk("quiet busy", IDX_STATUS, 32'h0000_0080);
            wait_sync;
            rdchk("no sync done", IDX_FLAGS, 32'h0000_0000);
        end
        $display("quiet sync done");
    endtask
    task automatic t_unmapped;
        wr(8'h20, 32'h0000_000f, r);
        chk("unmapped bresp", r, RESP_SLVERR);
        rd(8'h20, d, r);
        chk("unmapped rresp", r, RESP_SLVERR);
        chk("unmapped rdata", d, 32'h0000_0000);
        wrok(IDX_RESULT, 32'h0000_ffff);
        wrok(IDX_STATUS, 32'h0000_00ff);
        rdchk("result read only", IDX_RESULT, 32'h0000_0800);
        rdchk("status read only", IDX_STATUS, 32'h0000_0000);
        $display("unmapped done");
    endtask
    // ****************************************
    // Run control
    // ****************************************
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude;
        end
    end
    // Reset then scenarios
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'h1;
        @(posedge ref_clk);
        t_reset;
        t_enable;
        t_result;
        t_window;
        t_quiet;
        t_unmapped;
        conclude;
    end
endmodule
`default_nettype wire
